// ### logic/wakeup_timer.v
// Functional notes
// - Timer 3 count readable as high, low bytes
// - Control bit 7 shows timer running
// - Running changes with strobe bit 6, or clears when the timer stops at zero
// - Auto-trim starts trimming on each underflow
// - Auto card-detect runs detection sequence on underflow
// - Card detection restarts timer without gap
// - Timer 3 times field-on during detection
// - Auto-restart or auto card-detect reloads; otherwise stops at zero
// - Underflow sets the interrupt request flag
// - Auto-wake wakes chip on underflow
// - Clock select: 1, /8, /16, /32
// - Reload loaded at start event and on underflow with auto-restart or auto card-detect
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_defines.vh"

module wakeup_timer (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Register port
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [7:0]  rdata,
	// Oscillator pin
	input  wire        lfo_clk_pin,
	// Timer 3 link
	input  wire [15:0] timer3_count,
	output reg         timer3_field_start,
	input  wire        timer3_expired,
	// Trimming engine
	output reg         trim_start,
	// Card detection engine
	output reg         card_detect_start,
	input  wire        card_detect_done,
	input  wire        card_found,
	// Power control
	output reg         wake_request,
	output reg         power_down_request,
	// Interrupt
	output wire        irq
);

	// Control register storage
	reg                  running_reg;
	reg                  auto_trim_reg;
	reg                  auto_card_reg;
	reg                  auto_restart_reg;
	reg                  auto_wake_reg;
	reg [1:0]            clock_select_reg;
	reg [7:0]            reload_high_reg;
	reg [7:0]            reload_low_reg;
	reg [15:0]           count_reg;
	reg [`IRQ_WIDTH-1:0] irq_status_reg;
	reg [`IRQ_WIDTH-1:0] irq_enable_reg;
	reg                  detect_busy_reg;
	reg                  field_on_reg;

	wire        lfo_tick;
	wire        count_tick;
	wire        ctrl_write;
	wire        start_stop;
	wire        start_event;
	wire        underflow;
	wire        card_event;
	wire [15:0] wakeup_reload_value;
	reg  [`IRQ_WIDTH-1:0] irq_set;
	reg  [`IRQ_WIDTH-1:0] irq_clear;

	lfo_tick_sync u_sync (
		.clk         (clk),
		.rst_n       (rst_n),
		.lfo_clk_pin (lfo_clk_pin),
		.lfo_tick    (lfo_tick)
	);

	wakeup_prescaler u_prescaler (
		.clk          (clk),
		.rst_n        (rst_n),
		.lfo_tick     (lfo_tick),
		.restart      (start_event),
		.clock_select (clock_select_reg),
		.count_tick   (count_tick)
	);

	assign wakeup_reload_value = {reload_high_reg, reload_low_reg};
	assign ctrl_write  = wr_en && (addr == `ADDR_WAKEUP_CONTROL);
	assign start_stop  = ctrl_write && wdata[`CTRL_STROBE_BIT];
	assign start_event = start_stop && wdata[`CTRL_RUNNING_BIT] && !running_reg;
	assign underflow   = running_reg && count_tick && (count_reg == 16'h0000);
	assign card_event  = detect_busy_reg && card_detect_done && card_found;

	// Control and reload registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_trim_reg    <= 1'b0;
			auto_card_reg    <= 1'b0;
			auto_restart_reg <= 1'b0;
			auto_wake_reg    <= 1'b0;
			clock_select_reg <= `CLKSEL_DIV1;
			reload_high_reg  <= `RELOAD_RESET;
			reload_low_reg   <= `RELOAD_RESET;
			irq_enable_reg   <= `IRQ_ENABLE_RESET;
		end else if (wr_en) begin
			case (addr)
				`ADDR_WAKEUP_CONTROL: begin
					auto_trim_reg    <= wdata[`CTRL_TRIM_BIT];
					auto_card_reg    <= wdata[`CTRL_CARD_BIT];
					auto_restart_reg <= wdata[`CTRL_RESTART_BIT];
					auto_wake_reg    <= wdata[`CTRL_WAKE_BIT];
					clock_select_reg <= wdata[`CTRL_CLKSEL_HI:`CTRL_CLKSEL_LO];
				end
				`ADDR_RELOAD_HIGH: reload_high_reg <= wdata;
				`ADDR_RELOAD_LOW:  reload_low_reg  <= wdata;
				`ADDR_IRQ_ENABLE:  irq_enable_reg  <= wdata[`IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	// Counter and running state
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			running_reg <= 1'b0;
			count_reg   <= 16'h0000;
		end else if (start_stop) begin
			running_reg <= wdata[`CTRL_RUNNING_BIT];
			if (start_event) begin
				count_reg <= wakeup_reload_value;
			end
		end else if (underflow) begin
			if (auto_restart_reg || auto_card_reg) begin
				count_reg <= wakeup_reload_value;
			end else begin
				running_reg <= 1'b0;
			end
		end else if (running_reg && count_tick) begin
			count_reg <= count_reg - 16'h0001;
		end
	end

	// Underflow actions
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_start        <= 1'b0;
			card_detect_start <= 1'b0;
			wake_request      <= 1'b0;
		end else begin
			trim_start        <= underflow && auto_trim_reg;
			card_detect_start <= underflow && auto_card_reg && !detect_busy_reg;
			wake_request      <= (underflow && auto_wake_reg) || card_event;
		end
	end

	// Card detection sequence tracking
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			detect_busy_reg    <= 1'b0;
			field_on_reg       <= 1'b0;
			timer3_field_start <= 1'b0;
			power_down_request <= 1'b0;
		end else begin
			timer3_field_start <= card_detect_start;
			power_down_request <= detect_busy_reg && card_detect_done && !card_found
				&& auto_wake_reg;
			if (card_detect_start) begin
				detect_busy_reg <= 1'b1;
				field_on_reg    <= 1'b1;
			end else begin
				if (card_detect_done) begin
					detect_busy_reg <= 1'b0;
				end
				if (timer3_expired || card_detect_done) begin
					field_on_reg <= 1'b0;
				end
			end
		end
	end

	// Interrupt status, set wins over clear
	always @* begin
		irq_set   = {`IRQ_WIDTH{1'b0}};
		irq_clear = {`IRQ_WIDTH{1'b0}};
		irq_set[`IRQ_UNDERFLOW_BIT] = underflow;
		irq_set[`IRQ_CARD_BIT]      = card_event;
		if (wr_en && (addr == `ADDR_IRQ_CLEAR)) begin
			irq_clear = wdata[`IRQ_WIDTH-1:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= {`IRQ_WIDTH{1'b0}};
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
		end
	end

	assign irq = |(irq_status_reg & irq_enable_reg);

	// Read data
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				`ADDR_T3_COUNT_HIGH:  rdata <= timer3_count[15:8];
				`ADDR_T3_COUNT_LOW:   rdata <= timer3_count[7:0];
				`ADDR_WAKEUP_CONTROL: rdata <= {running_reg, 1'b0, auto_trim_reg,
					auto_card_reg, auto_restart_reg, auto_wake_reg,
					clock_select_reg};
				`ADDR_RELOAD_HIGH:    rdata <= reload_high_reg;
				`ADDR_RELOAD_LOW:     rdata <= reload_low_reg;
				`ADDR_IRQ_STATUS:     rdata <= {6'h00, irq_status_reg};
				`ADDR_IRQ_ENABLE:     rdata <= {6'h00, irq_enable_reg};
				default:              rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule // wakeup_timer
`default_nettype wire

// ### logic/wakeup_timer_defines.vh
`ifndef WAKEUP_TIMER_DEFINES_VH
`define WAKEUP_TIMER_DEFINES_VH

// Register offsets
`define ADDR_T3_COUNT_HIGH   8'h21
`define ADDR_T3_COUNT_LOW    8'h22
`define ADDR_WAKEUP_CONTROL  8'h23
`define ADDR_RELOAD_HIGH     8'h24
`define ADDR_RELOAD_LOW      8'h25
`define ADDR_IRQ_STATUS      8'h30
`define ADDR_IRQ_ENABLE      8'h31
`define ADDR_IRQ_CLEAR       8'h32

// Control register fields
`define CTRL_RUNNING_BIT     7
`define CTRL_STROBE_BIT      6
`define CTRL_TRIM_BIT        5
`define CTRL_CARD_BIT        4
`define CTRL_RESTART_BIT     3
`define CTRL_WAKE_BIT        2
`define CTRL_CLKSEL_HI       1
`define CTRL_CLKSEL_LO       0

// Interrupt status fields
`define IRQ_UNDERFLOW_BIT    0
`define IRQ_CARD_BIT         1
`define IRQ_WIDTH            2

// Reset values
`define CTRL_RESET           6'h00
`define RELOAD_RESET         8'h00
`define IRQ_ENABLE_RESET     2'h0

// Clock select codes and prescale divisions
`define CLKSEL_DIV1          2'h0
`define CLKSEL_DIV8          2'h1
`define CLKSEL_DIV16         2'h2
`define CLKSEL_DIV32         2'h3
`define PRESCALE_WIDTH       5

`endif

// ### logic/lfo_tick_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_defines.vh"

module lfo_tick_sync (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Oscillator pin
	input  wire       lfo_clk_pin,
	// Tick out
	output wire       lfo_tick
);

	reg sync1_reg;
	reg sync2_reg;
	reg prev_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end else begin
			sync1_reg <= lfo_clk_pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Rising edge of the oscillator
	assign lfo_tick = sync2_reg & ~prev_reg;

endmodule // lfo_tick_sync
`default_nettype wire

// ### logic/wakeup_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_defines.vh"

module wakeup_prescaler (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Control
	input  wire       lfo_tick,
	input  wire       restart,
	input  wire [1:0] clock_select,
	// Tick out
	output reg        count_tick
);

	reg [`PRESCALE_WIDTH-1:0] div_reg;
	reg                       hit;

	always @* begin
		case (clock_select)
			`CLKSEL_DIV1:  hit = 1'b1;
			`CLKSEL_DIV8:  hit = (div_reg[2:0] == 3'h7);
			`CLKSEL_DIV16: hit = (div_reg[3:0] == 4'hf);
			default:       hit = (div_reg == 5'h1f);
		endcase
		count_tick = lfo_tick & hit;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 5'h00;
		end else if (restart) begin
			div_reg <= 5'h00;
		end else if (lfo_tick) begin
			div_reg <= div_reg + 5'h01;
		end
	end

endmodule // wakeup_prescaler
`default_nettype wire

// ### verif/wakeup_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_timer_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [7:0]  addr,
	input wire logic        rd_en,
	input wire logic [7:0]  rdata,
	// Engines
	input wire logic [15:0] timer3_count,
	input wire logic        timer3_field_start,
	input wire logic        trim_start,
	input wire logic        card_detect_start,
	input wire logic        wake_request
);
	wire logic [7:0] count_high = timer3_count[15:8];
	wire logic [7:0] count_low  = timer3_count[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_count_high: assert property (rd_en && addr == 8'h21 |=> rdata == $past(count_high))
		else $error("count high byte wrong");
	a_count_low: assert property (rd_en && addr == 8'h22 |=> rdata == $past(count_low))
		else $error("count low byte wrong");
	a_strobe_reads: assert property (rd_en && addr == 8'h23 |=> !rdata[6])
		else $error("strobe bit read back");
	a_trim_pulse: assert property (trim_start |=> !trim_start)
		else $error("trim start too long");
	a_card_pulse: assert property (card_detect_start |=> !card_detect_start)
		else $error("card start too long");
	a_field_follows: assert property (card_detect_start |=> timer3_field_start)
		else $error("field timing not started");
	a_field_cause: assert property (timer3_field_start |-> $past(card_detect_start))
		else $error("field timing without detection");
	a_wake_pulse: assert property (wake_request |=> !wake_request)
		else $error("wake request too long");
	cover property (trim_start);
	cover property (card_detect_start);
	cover property (wake_request);
endmodule // wakeup_timer_monitor
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'h0, rst_n = 1'h0, wr_en = 1'h0, rd_en = 1'h0, lfo_clk_pin = 1'h0;
	logic        timer3_expired = 1'h0, card_detect_done = 1'h0, card_found = 1'h0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, trims = 8'h00, cards = 8'h00, wakes = 8'h00;
	logic [15:0] timer3_count = 16'hbeef;
	wire  [7:0]  rdata;
	wire         timer3_field_start, trim_start, card_detect_start, wake_request, irq;
	wire         power_down_request;
	int          mismatches = 0, cmp_count = 0;
	logic [7:0]  rows [0:7][0:2] = '{'{8'h21, 8'h00, 8'hbe}, '{8'h22, 8'h00, 8'hef},
		'{8'h24, 8'ha5, 8'ha5}, '{8'h25, 8'h5a, 8'h5a}, '{8'h23, 8'haf, 8'h2f},
		'{8'h31, 8'h03, 8'h03}, '{8'h40, 8'hff, 8'h00}, '{8'h30, 8'hff, 8'h00}};

	wakeup_timer i_dut (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .lfo_clk_pin,
		.timer3_count, .timer3_field_start, .timer3_expired, .trim_start, .card_detect_start,
		.card_detect_done, .card_found, .wake_request, .power_down_request, .irq);

	initial forever #25 clk = ~clk;

	always @(posedge clk) begin
		trims <= trims + {7'h0, trim_start};
		cards <= cards + {7'h0, card_detect_start};
		wakes <= wakes + {7'h0, wake_request};
	end

	task automatic chk(input string n, input logic [7:0] e, s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		@(negedge clk);
		chk($sformatf("reg %h", a), e, rdata);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			lfo_clk_pin <= 1'h1;
			repeat (4) @(posedge clk);
			lfo_clk_pin <= 1'h0;
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#400000;
		mismatches++;
		stop_test;
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2]);
		end
		$display("test table done");
		wr(8'h24, 8'h00);
		wr(8'h25, 8'h02);
		wr(8'h23, 8'hcc);
		tick(2);
		@(negedge clk);
		chk("irq", 8'h00, {7'h0, irq});
		tick(1);
		@(negedge clk);
		chk("irq", 8'h01, {7'h0, irq});
		chk("wakes", 8'h01, wakes);
		wr(8'h32, 8'h03);
		wr(8'h31, 8'h00);
		tick(3);
		rd(8'h30, 8'h01);
		chk("irq", 8'h00, {7'h0, irq});
		wr(8'h31, 8'h01);
		@(negedge clk);
		chk("irq", 8'h01, {7'h0, irq});
		$display("test count done");
		for (int s = 1; s < 4; s++) begin
			wr(8'h23, 8'h40);
			wr(8'h32, 8'h03);
			wr(8'h25, 8'h00);
			wr(8'h23, {6'h32, s[1:0]});
			wr(8'h25, 8'hff);
			rd(8'h23, {6'h22, s[1:0]});
			tick((4 << s) - 1);
			@(negedge clk);
			chk("irq", 8'h00, {7'h0, irq});
			tick(1);
			@(negedge clk);
			chk("irq", 8'h01, {7'h0, irq});
		end
		$display("test select done");
		wr(8'h23, 8'h40);
		wr(8'h25, 8'h00);
		wr(8'h32, 8'h03);
		wr(8'h23, 8'hc0);
		tick(1);
		rd(8'h23, 8'h00);
		wr(8'h32, 8'h03);
		wr(8'h23, 8'hf4);
		tick(1);
		@(negedge clk);
		chk("trims", 8'h01, trims);
		chk("cards", 8'h01, cards);
		rd(8'h23, 8'hb4);
		@(posedge clk);
		card_detect_done <= 1'h1;
		card_found <= 1'h1;
		@(posedge clk);
		card_detect_done <= 1'h0;
		@(negedge clk);
		chk("power down", 8'h00, {7'h0, power_down_request});
		rd(8'h30, 8'h03);
		chk("wakes", 8'h04, wakes);
		$display("test detect done");
		wr(8'h23, 8'h14);
		@(posedge clk);
		lfo_clk_pin <= 1'h1;
		@(posedge clk);
		wr(8'h32, 8'h03);
		lfo_clk_pin <= 1'h0;
		rd(8'h30, 8'h01);
		@(posedge clk);
		card_detect_done <= 1'h1;
		card_found <= 1'h0;
		@(posedge clk);
		card_detect_done <= 1'h0;
		@(negedge clk);
		chk("power down", 8'h01, {7'h0, power_down_request});
		chk("cards", 8'h02, cards);
		chk("wakes", 8'h05, wakes);
		$display("test power down done");
		wr(8'h24, 8'h5a);
		rd(8'h24, 8'h5a);
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		rd(8'h23, 8'h00);
		rd(8'h24, 8'h00);
		rd(8'h31, 8'h00);
		rd(8'h30, 8'h00);
		$display("test reset done");
		stop_test;
	end
endmodule // tb

bind wakeup_timer wakeup_timer_monitor i_mon (.clk, .rst_n, .addr, .rd_en, .rdata, .timer3_count,
	.timer3_field_start, .trim_start, .card_detect_start, .wake_request);
`default_nettype wire
